// >>> logic/hcmbx_defs.svh
// host-core mailbox: offsets, field positions, reset values
`ifndef HCMBX_DEFS_SVH
`define HCMBX_DEFS_SVH

`define HCMBX_HALF_W 16
`define HCMBX_ADDR_W 6

// core register locations
`define HCMBX_OFF_UPPER 6'h28
`define HCMBX_OFF_LOWER 6'h29
`define HCMBX_OFF_STATE 6'h2A

// flag positions inside the external state bits
`define HCMBX_BIT_INBOUND 6
`define HCMBX_BIT_OUTBOUND 7

// reset values
`define HCMBX_RST_HALF 16'h0000
`define HCMBX_RST_FLAG 1'b0

`endif

// >>> logic/hcmbx_pkg.sv
// host-core mailbox: shared types
package hcmbx_pkg;

	// one-hot core register selection
	typedef enum logic [3:0] {
		HCMBX_SEL_NONE = 4'h1,
		HCMBX_SEL_UPPER = 4'h2,
		HCMBX_SEL_LOWER = 4'h4,
		HCMBX_SEL_STATE = 4'h8
	} hcmbx_csel_t;

endpackage

// >>> logic/hcmbx_half.sv
// host-core mailbox: one 16-bit half, inbound and outbound storage
`timescale 1ns/100ps
`include "hcmbx_defs.svh"

module hcmbx_half #(
	parameter int HALF_W = `HCMBX_HALF_W
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic host_load_i,
	input wire logic [HALF_W-1:0] host_data_i,
	input wire logic core_load_i,
	input wire logic [HALF_W-1:0] core_data_i,
	output logic [HALF_W-1:0] inbound_o,
	output logic [HALF_W-1:0] outbound_o
);

	logic [HALF_W-1:0] inbound_reg;
	logic [HALF_W-1:0] inbound_next;
	logic [HALF_W-1:0] outbound_reg;
	logic [HALF_W-1:0] outbound_next;

	// separate words per direction, so neither side overwrites the other
	always_comb begin
		inbound_next = inbound_reg;
		outbound_next = outbound_reg;
		if (host_load_i) begin
			inbound_next = host_data_i;
		end
		if (core_load_i) begin
			outbound_next = core_data_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			inbound_reg <= HALF_W'(`HCMBX_RST_HALF);
			outbound_reg <= HALF_W'(`HCMBX_RST_HALF);
		end else begin
			inbound_reg <= inbound_next;
			outbound_reg <= outbound_next;
		end
	end

	assign inbound_o = inbound_reg;
	assign outbound_o = outbound_reg;

endmodule

// >>> logic/hcmbx_top.sv
// host-core mailbox: flags, core register access, host port and checks
`timescale 1ns/100ps
`include "hcmbx_defs.svh"


module hcmbx_top #(
	parameter int HALF_W = `HCMBX_HALF_W,
	parameter int ADDR_W = `HCMBX_ADDR_W
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// primary memory port side
	input wire logic mailbox_select_i,
	input wire logic host_wr_i,
	input wire logic host_rd_i,
	input wire logic [2*HALF_W-1:0] host_wdata_i,
	output logic [2*HALF_W-1:0] host_rdata_o,
	output logic inbound_pending_pin_o,
	output logic outbound_pending_pin_o,
	// embedded core side
	input wire logic [ADDR_W-1:0] core_addr_i,
	input wire logic core_wr_i,
	input wire logic core_rd_i,
	input wire logic core_nullified_i,
	input wire logic [HALF_W-1:0] core_wdata_i,
	output logic [HALF_W-1:0] core_rdata_o,
	output logic [HALF_W-1:0] external_state_bits_o
);

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------

	function automatic hcmbx_pkg::hcmbx_csel_t csel_of(input logic [ADDR_W-1:0] addr);
		hcmbx_pkg::hcmbx_csel_t sel;
		sel = hcmbx_pkg::HCMBX_SEL_NONE;
		case (addr)
			ADDR_W'(`HCMBX_OFF_UPPER): sel = hcmbx_pkg::HCMBX_SEL_UPPER;
			ADDR_W'(`HCMBX_OFF_LOWER): sel = hcmbx_pkg::HCMBX_SEL_LOWER;
			ADDR_W'(`HCMBX_OFF_STATE): sel = hcmbx_pkg::HCMBX_SEL_STATE;
			default: sel = hcmbx_pkg::HCMBX_SEL_NONE;
		endcase
		return sel;
	endfunction

	// other state bits belong to other blocks and read zero here
	function automatic logic [HALF_W-1:0] state_word(input logic inb, input logic outb);
		logic [HALF_W-1:0] w;
		w = '0;
		w[`HCMBX_BIT_INBOUND] = inb;
		w[`HCMBX_BIT_OUTBOUND] = outb;
		return w;
	endfunction

	// ------------------------------------------------------------
	// access decode
	// ------------------------------------------------------------

	hcmbx_pkg::hcmbx_csel_t csel;
	logic host_write;
	logic host_read;
	logic core_upper_rd;
	logic core_upper_wr;
	logic core_lower_wr;
	logic core_upper_touch;

	assign csel = csel_of(core_addr_i);
	assign host_write = mailbox_select_i && host_wr_i;
	assign host_read = mailbox_select_i && host_rd_i;
	// a nullified instruction must not store anything
	// only upper half strobes reach the flags, so software moves the lower half first
	assign core_upper_wr = core_wr_i && !core_nullified_i && (csel == hcmbx_pkg::HCMBX_SEL_UPPER);
	assign core_lower_wr = core_wr_i && !core_nullified_i && (csel == hcmbx_pkg::HCMBX_SEL_LOWER);
	assign core_upper_rd = core_rd_i && !core_nullified_i && (csel == hcmbx_pkg::HCMBX_SEL_UPPER);
	// hazard kept on purpose: nullified upper access still counts as consuming
	assign core_upper_touch = (core_rd_i || core_wr_i) && core_nullified_i
		&& (csel == hcmbx_pkg::HCMBX_SEL_UPPER);

	// ------------------------------------------------------------
	// mailbox storage
	// ------------------------------------------------------------

	logic [HALF_W-1:0] in_upper;
	logic [HALF_W-1:0] in_lower;
	logic [HALF_W-1:0] out_upper;
	logic [HALF_W-1:0] out_lower;

	hcmbx_half #(
		.HALF_W(HALF_W)
	) u_upper (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.host_load_i(host_write),
		.host_data_i(host_wdata_i[2*HALF_W-1:HALF_W]),
		.core_load_i(core_upper_wr),
		.core_data_i(core_wdata_i),
		.inbound_o(in_upper),
		.outbound_o(out_upper)
	);

	hcmbx_half #(
		.HALF_W(HALF_W)
	) u_lower (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.host_load_i(host_write),
		.host_data_i(host_wdata_i[HALF_W-1:0]),
		.core_load_i(core_lower_wr),
		.core_data_i(core_wdata_i),
		.inbound_o(in_lower),
		.outbound_o(out_lower)
	);

	// ------------------------------------------------------------
	// pending flags
	// ------------------------------------------------------------

	logic inbound_pending_reg;
	logic inbound_pending_next;
	logic outbound_pending_reg;
	logic outbound_pending_next;

	// set wins over clear so a same-cycle event is never lost
	always_comb begin
		inbound_pending_next = inbound_pending_reg;
		outbound_pending_next = outbound_pending_reg;
		if (core_upper_rd || core_upper_touch) begin
			inbound_pending_next = 1'b0;
		end
		if (host_write) begin
			inbound_pending_next = 1'b1;
		end
		if (host_read) begin
			outbound_pending_next = 1'b0;
		end
		if (core_upper_wr) begin
			outbound_pending_next = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			inbound_pending_reg <= `HCMBX_RST_FLAG;
			outbound_pending_reg <= `HCMBX_RST_FLAG;
		end else begin
			inbound_pending_reg <= inbound_pending_next;
			outbound_pending_reg <= outbound_pending_next;
		end
	end

	assign inbound_pending_pin_o = inbound_pending_reg;
	assign outbound_pending_pin_o = outbound_pending_reg;
	assign external_state_bits_o = state_word(inbound_pending_reg, outbound_pending_reg);

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------

	logic [HALF_W-1:0] core_rdata_reg;
	logic [HALF_W-1:0] core_rdata_next;
	logic [2*HALF_W-1:0] host_rdata_reg;
	logic [2*HALF_W-1:0] host_rdata_next;

	// read data hold until the next read of the same side
	always_comb begin
		core_rdata_next = core_rdata_reg;
		host_rdata_next = host_rdata_reg;
		if (core_rd_i) begin
			case (csel)
				hcmbx_pkg::HCMBX_SEL_UPPER: core_rdata_next = in_upper;
				hcmbx_pkg::HCMBX_SEL_LOWER: core_rdata_next = in_lower;
				hcmbx_pkg::HCMBX_SEL_STATE: core_rdata_next = external_state_bits_o;
				default: core_rdata_next = '0;
			endcase
		end
		if (host_read) begin
			host_rdata_next = {out_upper, out_lower};
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			core_rdata_reg <= '0;
			host_rdata_reg <= '0;
		end else begin
			core_rdata_reg <= core_rdata_next;
			host_rdata_reg <= host_rdata_next;
		end
	end

	assign core_rdata_o = core_rdata_reg;
	assign host_rdata_o = host_rdata_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------

	default clocking cb @(posedge clk_sys_i);
	endclocking

	default disable iff (!rst_n_i);

	sequence s_host_wr;
		mailbox_select_i && host_wr_i;
	endsequence

	sequence s_host_rd;
		mailbox_select_i && host_rd_i;
	endsequence

	sequence s_core_hi_consume;
		(core_rd_i || (core_wr_i && core_nullified_i)) && (core_addr_i == ADDR_W'(`HCMBX_OFF_UPPER));
	endsequence

	sequence s_core_hi_store;
		core_wr_i && !core_nullified_i && (core_addr_i == ADDR_W'(`HCMBX_OFF_UPPER));
	endsequence

	sequence s_core_lo_only;
		(core_rd_i || core_wr_i) && (core_addr_i == ADDR_W'(`HCMBX_OFF_LOWER))
			&& !mailbox_select_i;
	endsequence

	a_inbound_set_on_wr: assert property (s_host_wr |=> inbound_pending_pin_o)
		else $error("inbound pending not set after host write");

	a_inbound_holds_high: assert property (
		inbound_pending_pin_o && !(core_rd_i || core_wr_i) |=> inbound_pending_pin_o)
		else $error("inbound pending dropped without core access");

	a_inbound_clr_rd: assert property (
		s_core_hi_consume ##0 !(mailbox_select_i && host_wr_i) |=> !inbound_pending_pin_o)
		else $error("inbound pending not cleared by upper half read");

	a_inbound_clr_null: assert property (
		core_nullified_i && core_rd_i && (core_addr_i == ADDR_W'(`HCMBX_OFF_UPPER)) && !host_wr_i
		|=> !inbound_pending_pin_o)
		else $error("nullified upper access did not clear inbound pending");

	// set wins: a host write in the same cycle as an upper read must not be lost
	a_inbound_set_wins: assert property (s_host_wr ##0 s_core_hi_consume |=> inbound_pending_pin_o)
		else $error("inbound pending lost when host write met upper read");

	a_outbound_holds_high: assert property (
		outbound_pending_pin_o && !(mailbox_select_i && host_rd_i) |=> outbound_pending_pin_o)
		else $error("outbound pending dropped without host read");

	a_null_wr_no_out: assert property (
		core_wr_i && core_nullified_i && !outbound_pending_pin_o |=> !outbound_pending_pin_o)
		else $error("nullified core write raised outbound pending");

	a_outbound_set_wr: assert property (s_core_hi_store |=> outbound_pending_pin_o ##1 1'b1)
		else $error("outbound pending not set after core upper write");

	a_outbound_clr_rd: assert property (
		s_host_rd ##0 !(core_wr_i && !core_nullified_i) |=> !outbound_pending_pin_o)
		else $error("outbound pending not cleared by host read");

	a_lower_no_flags: assert property (
		s_core_lo_only |=> $stable(inbound_pending_pin_o) && $stable(outbound_pending_pin_o))
		else $error("lower half access changed a flag");

	a_state_bit_six: assert property (
		external_state_bits_o[`HCMBX_BIT_INBOUND] == inbound_pending_pin_o)
		else $error("state bit six does not follow inbound pending");

	a_state_bit_seven: assert property (
		external_state_bits_o[`HCMBX_BIT_OUTBOUND] == outbound_pending_pin_o)
		else $error("state bit seven does not follow outbound pending");

	a_state_read_data: assert property (
		core_rd_i && (core_addr_i == ADDR_W'(`HCMBX_OFF_STATE))
		|=> core_rdata_o == $past(external_state_bits_o))
		else $error("state register read returned wrong data");

	a_host_read_data: assert property (
		s_host_rd |=> host_rdata_o == $past({out_upper, out_lower}))
		else $error("host read returned wrong outbound word");

	a_host_to_core: assert property (
		s_host_wr ##1 (core_rd_i && (core_addr_i == ADDR_W'(`HCMBX_OFF_UPPER)) && !mailbox_select_i)
		|=> core_rdata_o == $past(host_wdata_i[2*HALF_W-1:HALF_W], 2))
		else $error("core did not read the upper half the host wrote");

	a_reset_flags_clear: assert property (
		$rose(rst_n_i) |-> !inbound_pending_pin_o && !outbound_pending_pin_o)
		else $error("pending flags not clear after reset");

endmodule

// >>> tb/hcmbx_host_model.sv
// host-side model of the primary memory port
`timescale 1ns/100ps

module hcmbx_host_model (
	input wire logic clk_sys_i,
	input wire logic inbound_pending_pin_i,
	input wire logic [31:0] host_rdata_i,
	output logic mailbox_select_o,
	output logic host_wr_o,
	output logic host_rd_o,
	output logic [31:0] host_wdata_o
);
	initial begin
		mailbox_select_o = 1'b0;
		host_wr_o = 1'b0;
		host_rd_o = 1'b0;
		host_wdata_o = 32'h0000_0000;
	end

	// one 32-bit access carries both halves, called at a falling edge
	task automatic write_word(input logic [31:0] w, output logic ok);
		int n;
		n = 0;
		ok = 1'b1;
		// never overwrite a word the core has not consumed
		while (inbound_pending_pin_i !== 1'b0) begin
			@(negedge clk_sys_i);
			n++;
			if (n > 50) begin
				ok = 1'b0;
				return;
			end
		end
		mailbox_select_o = 1'b1;
		host_wr_o = 1'b1;
		host_wdata_o = w;
		@(negedge clk_sys_i);
		mailbox_select_o = 1'b0;
		host_wr_o = 1'b0;
		// released data must not keep looking valid
		host_wdata_o = ~w;
	endtask

	task automatic read_word(output logic [31:0] r);
		mailbox_select_o = 1'b1;
		host_rd_o = 1'b1;
		@(negedge clk_sys_i);
		r = host_rdata_i;
		mailbox_select_o = 1'b0;
		host_rd_o = 1'b0;
		// let an edge pass so a following access never reassigns select in this step
		@(negedge clk_sys_i);
	endtask
endmodule

// >>> tb/hcmbx_top_tb.sv
// self-checking bench for the host-core mailbox
`timescale 1ns/100ps

module hcmbx_top_tb;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic sel, hwr, hrd, cwr, crd, cnul, ok;
	logic [31:0] hwd, hrd_data, r;
	logic [5:0] cadr = 6'h00;
	logic [15:0] cwd = 16'h0000;
	logic [15:0] crd_data, external_state_bits;
	logic inb, outb;
	int failures = 0;
	int n_tests = 0;

	always #10 clk_sys_i = ~clk_sys_i;

	hcmbx_host_model host (.clk_sys_i(clk_sys_i), .inbound_pending_pin_i(inb), .host_rdata_i(hrd_data),
		.mailbox_select_o(sel), .host_wr_o(hwr), .host_rd_o(hrd), .host_wdata_o(hwd));

	hcmbx_top DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .mailbox_select_i(sel), .host_wr_i(hwr),
		.host_rd_i(hrd), .host_wdata_i(hwd), .host_rdata_o(hrd_data), .inbound_pending_pin_o(inb),
		.outbound_pending_pin_o(outb), .core_addr_i(cadr), .core_wr_i(cwr), .core_rd_i(crd),
		.core_nullified_i(cnul), .core_wdata_i(cwd), .core_rdata_o(crd_data), .external_state_bits_o(external_state_bits));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic wrap_up();
		if (failures == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic core_op(input logic w, input logic [5:0] a, input logic [15:0] d, input logic nl);
		cwr = w;
		crd = !w;
		cadr = a;
		cwd = d;
		cnul = nl;
		@(negedge clk_sys_i);
		cwr = 1'b0;
		crd = 1'b0;
		cnul = 1'b0;
		cwd = ~d;
		@(negedge clk_sys_i);
	endtask

	task automatic hwrite(input logic [31:0] w);
		host.write_word(w, ok);
		if (ok !== 1'b1) begin
			failures++;
			wrap_up();
		end
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic sc_reset();
		chk({30'h0, inb, outb}, 32'h0);
		chk({16'h0, external_state_bits}, 32'h0);
		core_op(1'b0, 6'h2A, 16'h0000, 1'b0);
		chk({16'h0, crd_data}, 32'h0);
	endtask

	task automatic sc_inbound();
		hwrite(32'hA5C3_1E0F);
		chk({31'h0, inb}, 32'h1);
		chk({16'h0, external_state_bits}, 32'h0040);
		core_op(1'b0, 6'h29, 16'h0000, 1'b0);
		chk({16'h0, crd_data}, 32'h1E0F);
		chk({31'h0, inb}, 32'h1);
		core_op(1'b0, 6'h28, 16'h0000, 1'b0);
		chk({16'h0, crd_data}, 32'hA5C3);
		chk({31'h0, inb}, 32'h0);
		core_op(1'b0, 6'h30, 16'h0000, 1'b0);
		chk({16'h0, crd_data}, 32'h0);
	endtask

	task automatic sc_outbound();
		core_op(1'b1, 6'h29, 16'h55AA, 1'b0);
		chk({31'h0, outb}, 32'h0);
		core_op(1'b1, 6'h28, 16'h3C96, 1'b0);
		chk({31'h0, outb}, 32'h1);
		core_op(1'b0, 6'h2A, 16'h0000, 1'b0);
		chk({16'h0, crd_data}, 32'h0080);
		chk({16'h0, external_state_bits}, 32'h0080);
		host.read_word(r);
		chk(r, 32'h3C96_55AA);
		chk({31'h0, outb}, 32'h0);
		chk({16'h0, external_state_bits}, 32'h0);
	endtask

	task automatic sc_nullify();
		// the nullified slot hazard: the flag still drops
		hwrite(32'h0F0F_F0F0);
		core_op(1'b0, 6'h28, 16'h0000, 1'b1);
		chk({31'h0, inb}, 32'h0);
		hwrite(32'h1234_5678);
		core_op(1'b1, 6'h28, 16'hBEEF, 1'b1);
		chk({30'h0, inb, outb}, 32'h0);
		// a nullified write stores nothing: the host still sees the old word
		host.read_word(r);
		chk(r, 32'h3C96_55AA);
		chk({31'h0, outb}, 32'h0);
	endtask

	task automatic sc_collide();
		// set wins on both flags when event and clear meet in one cycle
		fork
			hwrite(32'hC0DE_0001);
			core_op(1'b0, 6'h28, 16'h0000, 1'b0);
		join
		chk({31'h0, inb}, 32'h1);
		chk({16'h0, crd_data}, 32'h1234);
		fork
			host.read_word(r);
			core_op(1'b1, 6'h28, 16'h7E81, 1'b0);
		join
		chk(r, 32'h3C96_55AA);
		chk({31'h0, outb}, 32'h1);
		core_op(1'b0, 6'h28, 16'h0000, 1'b0);
		chk({16'h0, crd_data}, 32'hC0DE);
		chk({31'h0, inb}, 32'h0);
		host.read_word(r);
		chk(r, 32'h7E81_55AA);
		chk({31'h0, outb}, 32'h0);
	endtask

	initial begin
		cwr = 1'b0;
		crd = 1'b0;
		cnul = 1'b0;
		repeat (6) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		@(negedge clk_sys_i);
		sc_reset();
		sc_inbound();
		sc_outbound();
		sc_nullify();
		sc_collide();
		wrap_up();
	end
endmodule
